// ### common/rop_defs.vh
`ifndef ROP_DEFS_VH
`define ROP_DEFS_VH

// Register byte offsets
`define ROP_OFS_OUT_STATE   8'h00
`define ROP_OFS_MODE        8'h04
`define ROP_OFS_RATIO_SEL   8'h08
`define ROP_OFS_RATIO       8'h0C
`define ROP_OFS_PHYS_STATE  8'h10
`define ROP_OFS_STATUS      8'h14
`define ROP_OFS_DRIVE       8'h18

// Ratio register fields
`define ROP_ON_LSB          0
`define ROP_OFF_LSB         8
`define ROP_SEL_BITS        3

// Status register fields
`define ROP_STAT_STRM_BIT   0

// Reset values
`define ROP_RST_STATE       16'h0000
`define ROP_RST_MODE        16'h0000
`define ROP_RST_DUR         8'h00

// AXI responses
`define ROP_RESP_OKAY       2'b00
`define ROP_RESP_SLVERR     2'b10

// Timebase
`define ROP_CLK_HZ          200000000
`define ROP_TICK_MS         2
`define ROP_TICK_CYC        (`ROP_CLK_HZ / 1000 * `ROP_TICK_MS)
`define ROP_DEBOUNCE_MS     10
`define ROP_DEBOUNCE_TICKS  (`ROP_DEBOUNCE_MS / `ROP_TICK_MS)

`endif

// ### core/rop_relay_pwm.v
// Function
// - Channel bits are laid out channel 0 at bit 0 up to channel 15 at bit 15, low byte first.
// - Writing output states sets the programmed state of every channel in an enabled byte lane at once.
// - Reading output states returns the programmed states, not the physical levels.
// - Writing modes puts bit-one channels 0 to 7 in pulse mode; bit-zero channels and channels 8 to 15 stay in plain mode.
// - Each pulse channel stores an 8-bit on-duration in 2 ms units.
// - Each pulse channel stores an 8-bit off-duration in 2 ms units.
// - A ratio read returns the on and off durations of one channel, a byte each.
// - A mode read returns the mode bits in the same channel order.
// - Physical states are sampled every 2 ms and debounced over 10 ms.
// - A stream error sets a sticky flag that stays until a clear action.
`timescale 1ns/1ps
`include "rop_defs.vh"

module rop_relay_pwm #(
    parameter N_CH      = 16,
    parameter N_PWM     = 8,
    parameter TICK_CYC  = `ROP_TICK_CYC,
    parameter DB_TICKS  = `ROP_DEBOUNCE_TICKS
) (
    input  wire                 sys_clk,
    input  wire                 rst,
    input  wire [7:0]           s_axi_awaddr,
    input  wire                 s_axi_awvalid,
    output reg                  s_axi_awready,
    input  wire [31:0]          s_axi_wdata,
    input  wire [3:0]           s_axi_wstrb,
    input  wire                 s_axi_wvalid,
    output reg                  s_axi_wready,
    output reg  [1:0]           s_axi_bresp,
    output reg                  s_axi_bvalid,
    input  wire                 s_axi_bready,
    input  wire [7:0]           s_axi_araddr,
    input  wire                 s_axi_arvalid,
    output reg                  s_axi_arready,
    output reg  [31:0]          s_axi_rdata,
    output reg  [1:0]           s_axi_rresp,
    output reg                  s_axi_rvalid,
    input  wire                 s_axi_rready,
    input  wire [N_CH-1:0]      phys_in,
    input  wire                 stream_err,
    output reg  [N_CH-1:0]      relay_out
);

    reg  [N_CH-1:0]     state_q;
    reg  [N_CH-1:0]     mode_q;
    reg  [2:0]          sel_q;
    reg  [7:0]          on_q    [0:N_PWM-1];
    reg  [7:0]          off_q   [0:N_PWM-1];
    reg                 strm_q;
    reg  [31:0]         tick_cnt_q;
    reg                 tick_q;
    reg  [N_CH-1:0]     phys_q;
    reg  [7:0]          awaddr_q;
    reg                 aw_have_q;
    reg  [31:0]         wdata_q;
    reg  [3:0]          wstrb_q;
    reg                 w_have_q;

    wire                aw_take = s_axi_awvalid & s_axi_awready;
    wire                w_take  = s_axi_wvalid & s_axi_wready;
    wire [7:0]          wa      = aw_have_q ? awaddr_q : s_axi_awaddr;
    wire [31:0]         wd      = w_have_q ? wdata_q : s_axi_wdata;
    wire [3:0]          ws      = w_have_q ? wstrb_q : s_axi_wstrb;
    wire                wr_go   = (aw_have_q | aw_take) & (w_have_q | w_take)
                                  & ~s_axi_bvalid;
    wire                clr_strm = wr_go & (wa == `ROP_OFS_STATUS) & ws[0]
                                   & wd[`ROP_STAT_STRM_BIT];

    // Write address and data accepted in either order, one write at a time
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h00000000;
            wstrb_q       <= 4'h0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `ROP_RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_have_q & ~aw_take & ~s_axi_bvalid & ~wr_go;
            s_axi_wready  <= ~w_have_q & ~w_take & ~s_axi_bvalid & ~wr_go;
            if (aw_take) begin
                awaddr_q  <= s_axi_awaddr;
                aw_have_q <= 1'b1;
            end
            if (w_take) begin
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
                w_have_q <= 1'b1;
            end
            if (wr_go) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (wa)
                    `ROP_OFS_OUT_STATE, `ROP_OFS_MODE, `ROP_OFS_RATIO_SEL,
                    `ROP_OFS_RATIO, `ROP_OFS_STATUS:
                        s_axi_bresp <= `ROP_RESP_OKAY;
                    default:
                        s_axi_bresp <= `ROP_RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Configuration registers; byte lanes honoured per 8-bit group
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= `ROP_RST_STATE;
            mode_q  <= `ROP_RST_MODE;
            sel_q   <= 3'h0;
        end else if (wr_go) begin
            if (wa == `ROP_OFS_OUT_STATE) begin
                if (ws[0])
                    state_q[7:0] <= wd[7:0];
                if (ws[1])
                    state_q[15:8] <= wd[15:8];
            end
            if (wa == `ROP_OFS_MODE) begin
                if (ws[0])
                    mode_q[7:0] <= wd[7:0];
                if (ws[1])
                    mode_q[15:8] <= wd[15:8];
            end
            if (wa == `ROP_OFS_RATIO_SEL && ws[0])
                sel_q <= wd[`ROP_SEL_BITS-1:0];
        end
    end

    // Stream error is sticky; a new error in the clear cycle wins
    always @(posedge sys_clk or posedge rst) begin
        if (rst)
            strm_q <= 1'b0;
        else if (stream_err)
            strm_q <= 1'b1;
        else if (clr_strm)
            strm_q <= 1'b0;
    end

    // 2 ms timebase pulse
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tick_cnt_q <= 32'h00000000;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q == TICK_CYC - 1) begin
            tick_cnt_q <= 32'h00000000;
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h00000001;
            tick_q     <= 1'b0;
        end
    end

    genvar g;
    generate
        for (g = 0; g < N_CH; g = g + 1) begin : g_ch
            reg [3:0] db_cnt_q;
            reg       smp_q;
            // Level must hold over DB_TICKS samples before it is reported
            always @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    db_cnt_q  <= 4'h0;
                    smp_q     <= 1'b0;
                    phys_q[g] <= 1'b0;
                end else if (tick_q) begin
                    smp_q <= phys_in[g];
                    if (phys_in[g] != smp_q)
                        db_cnt_q <= 4'h0;
                    else if (db_cnt_q < DB_TICKS[3:0] - 4'h1)
                        db_cnt_q <= db_cnt_q + 4'h1;
                    else
                        phys_q[g] <= smp_q;
                end
            end

            if (g < N_PWM) begin : g_pwm
                reg       ph_q;
                reg [7:0] cnt_q;
                always @(posedge sys_clk or posedge rst) begin
                    if (rst) begin
                        on_q[g]  <= `ROP_RST_DUR;
                        off_q[g] <= `ROP_RST_DUR;
                    end else if (wr_go && wa == `ROP_OFS_RATIO &&
                                 sel_q == g) begin
                        if (ws[0])
                            on_q[g] <= wd[`ROP_ON_LSB+7:`ROP_ON_LSB];
                        if (ws[1])
                            off_q[g] <= wd[`ROP_OFF_LSB+7:`ROP_OFF_LSB];
                    end
                end
                // Zero duration skips that phase; both zero holds inactive
                always @(posedge sys_clk or posedge rst) begin
                    if (rst) begin
                        ph_q         <= 1'b0;
                        cnt_q        <= 8'h00;
                        relay_out[g] <= 1'b0;
                    end else if (!mode_q[g]) begin
                        ph_q         <= 1'b0;
                        cnt_q        <= 8'h00;
                        relay_out[g] <= state_q[g];
                    end else if (tick_q) begin
                        if (cnt_q != 8'h00) begin
                            cnt_q <= cnt_q - 8'h01;
                        end else if (on_q[g] != 8'h00 &&
                                     (!ph_q || off_q[g] == 8'h00)) begin
                            ph_q         <= 1'b1;
                            cnt_q        <= on_q[g] - 8'h01;
                            relay_out[g] <= 1'b1;
                        end else begin
                            ph_q         <= 1'b0;
                            cnt_q        <= (off_q[g] == 8'h00) ? 8'h00
                                            : off_q[g] - 8'h01;
                            relay_out[g] <= 1'b0;
                        end
                    end
                end
            end else begin : g_std
                // Channels without ratio storage stay plain-driven
                always @(posedge sys_clk or posedge rst) begin
                    if (rst)
                        relay_out[g] <= 1'b0;
                    else
                        relay_out[g] <= state_q[g];
                end
            end
        end
    endgenerate

    // Read channel: one read at a time, answer the cycle after acceptance
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `ROP_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `ROP_RESP_OKAY;
                s_axi_rdata  <= 32'h00000000;
                case (s_axi_araddr)
                    `ROP_OFS_OUT_STATE:
                        s_axi_rdata[15:0] <= state_q;
                    `ROP_OFS_MODE:
                        s_axi_rdata[15:0] <= mode_q;
                    `ROP_OFS_RATIO_SEL:
                        s_axi_rdata[2:0] <= sel_q;
                    `ROP_OFS_RATIO: begin
                        s_axi_rdata[15:0] <= {off_q[sel_q], on_q[sel_q]};
                    end
                    `ROP_OFS_PHYS_STATE:
                        s_axi_rdata[15:0] <= phys_q;
                    `ROP_OFS_STATUS:
                        s_axi_rdata[`ROP_STAT_STRM_BIT] <= strm_q;
                    `ROP_OFS_DRIVE:
                        s_axi_rdata[15:0] <= relay_out;
                    default:
                        s_axi_rresp <= `ROP_RESP_SLVERR;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// ### test/rop_relay_pwm_properties.sv
`timescale 1ns/1ps
`include "rop_defs.vh"
module rop_relay_pwm_properties #(
    parameter N_CH = 16
) (
    input wire            sys_clk,
    input wire            rst,
    input wire [7:0]      s_axi_awaddr,
    input wire            s_axi_awvalid,
    input wire            s_axi_awready,
    input wire [31:0]     s_axi_wdata,
    input wire [3:0]      s_axi_wstrb,
    input wire            s_axi_wvalid,
    input wire            s_axi_wready,
    input wire [1:0]      s_axi_bresp,
    input wire            s_axi_bvalid,
    input wire            s_axi_bready,
    input wire [7:0]      s_axi_araddr,
    input wire            s_axi_arvalid,
    input wire            s_axi_arready,
    input wire [31:0]     s_axi_rdata,
    input wire [1:0]      s_axi_rresp,
    input wire            s_axi_rvalid,
    input wire            s_axi_rready,
    input wire [N_CH-1:0] relay_out
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire rd_go = s_axi_arvalid && s_axi_arready;
    a_write_answer: assert property (wr_go |=> s_axi_bvalid)
        else $error("no write response after handshake");
    a_read_answer: assert property (rd_go |=> s_axi_rvalid)
        else $error("no read data after handshake");
    a_rdata_held: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    a_bresp_held: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    a_write_blocked: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_plain_follow: assert property (
        wr_go && s_axi_awaddr == `ROP_OFS_OUT_STATE && s_axi_wstrb[1] |->
        ##2 relay_out[15:8] == $past(s_axi_wdata[15:8], 2))
        else $error("upper channels do not follow written state");
    a_unmapped_err: assert property (
        rd_go && s_axi_araddr > `ROP_OFS_DRIVE |=> s_axi_rresp == `ROP_RESP_SLVERR)
        else $error("unmapped read not refused");
    a_mapped_okay: assert property (
        rd_go && s_axi_araddr <= `ROP_OFS_DRIVE && s_axi_araddr[1:0] == 2'h0
        |=> s_axi_rresp == `ROP_RESP_OKAY)
        else $error("mapped read refused");
endmodule

// ### test/rop_relay_model.sv
`timescale 1ns/1ps
module rop_relay_model (
    input  wire        sys_clk,
    input  wire [15:0] relay_out,
    input  wire [15:0] ext_drive,
    input  wire        err_req,
    output reg  [15:0] phys_in = 16'h0000,
    output reg         stream_err = 1'b0
);
    // Monitor sees the driven level, inverted on channels where ext_drive is set
    always @(posedge sys_clk) begin
        phys_in <= relay_out ^ ext_drive;
        stream_err <= err_req;
    end
endmodule

// ### test/rop_relay_pwm_tb.sv
`timescale 1ns/1ps
`include "rop_defs.vh"
module rop_relay_pwm_tb;
    localparam TK = 10;
    localparam [1:0] OK = `ROP_RESP_OKAY;
    localparam [1:0] ER = `ROP_RESP_SLVERR;
    logic        sys_clk = 1'b0, rst = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, stream_err, err_req = 1'b0;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] phys_in, relay_out, ext_drive = 16'h0000, v, m, rt[8];
    logic [33:0] exp_q[$];
    logic [31:0] seed = 32'h5;
    int          miscompares = 0, check_count = 0, n;
    bit          slow = 1'b0;

    rop_relay_pwm #(.TICK_CYC(TK), .DB_TICKS(5)) i_rop_relay_pwm (.*);
    rop_relay_model i_rop_relay_model (.*);
    always #2.5 sys_clk = ~sys_clk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input string nm, input [33:0] s, input [33:0] x);
        check_count++;
        if (s !== x) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, x, s);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // A wait that runs out of cycles ends the run as a failure
    task automatic wait_out(input int k);
        if (k >= 200) begin
            miscompares++;
            end_sim();
        end
    endtask

    // One bus transfer; the expected answer is noted before the request goes out
    // With slow set, bready or rready comes late so the answer must stand
    task automatic xfer(input bit w, input [7:0] a, input [31:0] d,
                        input [3:0] s, input [33:0] e);
        @(posedge sys_clk);
        exp_q.push_back(e);
        if (w) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_wstrb <= s;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= !slow;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= !slow;
        end
        for (n = 0; n < 60; n++) begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready)
                break;
            if (n == 3 && slow) begin
                if (w)
                    s_axi_bready <= 1'b1;
                else
                    s_axi_rready <= 1'b1;
            end
        end
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        if (n == 60) begin
            miscompares++;
            end_sim();
        end
    endtask

    always @(posedge sys_clk) begin
        if (s_axi_bvalid && s_axi_bready)
            chk("bresp", {s_axi_bresp, 32'h0}, exp_q.pop_front());
        if (s_axi_rvalid && s_axi_rready)
            chk("rdata", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    end

    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++)
            xfer(0, 8'(i * 4), 0, 0, {OK, 32'h0});
        xfer(1, 8'h1C, 0, 4'hF, {ER, 32'h0});
        xfer(0, 8'h20, 0, 0, {ER, 32'h0});
        $display("test reset done");
        v = 16'(rnd());
        ext_drive <= 16'h8001;
        xfer(1, `ROP_OFS_OUT_STATE, {16'h0, v}, 4'hF, {OK, 32'h0});
        repeat (2) @(posedge sys_clk);
        chk("relay", {18'h0, relay_out}, {18'h0, v});
        xfer(1, `ROP_OFS_OUT_STATE, 32'h0000A500, 4'h2, {OK, 32'h0});
        v[15:8] = 8'hA5;
        xfer(0, `ROP_OFS_OUT_STATE, 0, 0, {OK, 16'h0, v});
        xfer(0, `ROP_OFS_DRIVE, 0, 0, {OK, 16'h0, v});
        repeat (8 * TK) @(posedge sys_clk);
        xfer(0, `ROP_OFS_PHYS_STATE, 0, 0, {OK, 16'h0, v ^ 16'h8001});
        $display("test states done");
        m = 16'(rnd()) | 16'h0001;
        xfer(1, `ROP_OFS_MODE, {16'h0, m}, 4'hF, {OK, 32'h0});
        xfer(0, `ROP_OFS_MODE, 0, 0, {OK, 16'h0, m});
        for (int c = 0; c < 8; c++) begin
            rt[c] = (c == 0) ? 16'h0302 : 16'(rnd());
            xfer(1, `ROP_OFS_RATIO_SEL, c, 4'hF, {OK, 32'h0});
            xfer(1, `ROP_OFS_RATIO, {16'h0, rt[c]}, 4'h3, {OK, 32'h0});
        end
        for (int c = 7; c >= 0; c--) begin
            xfer(1, `ROP_OFS_RATIO_SEL, c, 4'hF, {OK, 32'h0});
            xfer(0, `ROP_OFS_RATIO, 0, 0, {OK, 16'h0, rt[c]});
        end
        for (n = 0; n < 200 && relay_out[0] !== 1'b0; n++) @(posedge sys_clk);
        wait_out(n);
        for (n = 0; n < 200 && relay_out[0] !== 1'b1; n++) @(posedge sys_clk);
        wait_out(n);
        for (n = 0; n < 200 && relay_out[0] === 1'b1; n++) @(posedge sys_clk);
        chk("on_time", n, 2 * TK);
        for (n = 0; n < 200 && relay_out[0] === 1'b0; n++) @(posedge sys_clk);
        chk("off_time", n, 3 * TK);
        $display("test pulse done");
        slow = 1'b1;
        err_req <= 1'b1;
        @(posedge sys_clk);
        err_req <= 1'b0;
        repeat (2) xfer(0, `ROP_OFS_STATUS, 0, 0, {OK, 32'h1});
        xfer(1, `ROP_OFS_STATUS, 32'h1, 4'h1, {OK, 32'h0});
        xfer(0, `ROP_OFS_STATUS, 0, 0, {OK, 32'h0});
        $display("test status done");
        end_sim();
    end
endmodule

bind rop_relay_pwm rop_relay_pwm_properties #(.N_CH(N_CH)) i_props (.*);
